// ==== verilog/meim_pkg.sv ====
// Constants, register map and types for the metering engine input map
// Functional notes
// - Code 5 sums VA*IA, VB*IB, VC*IC on elements 0, 1, 2.
// - Codes 2, 3, 4 select two-element delta and wye formulas with half differences.
// - Raw samples readable at engine words 0 through 0xA, one per handle.
// - Eleven channels all single-ended; seven when all current pairs differential.
// - Pair-0 differential joins pins 0 and 1 into handle 0, location 0.
// - Local differential pair 2 joins pins 2, 3 into handle 2, location 2.
// - Remote pair needs no handle; isolation link writes its even location directly.
// - Voltages single-ended, never remote, handles and locations 8, 9, 10.
// - Slot select names handle 0 to 10; single-ended handle equals pin and location.
// - Pairs 2-3, 4-5, 6-7 each have own remote and differential enables.
// - Status word at engine address 0x80 holds sag flags and square wave.
// - Per-pass interrupt fires at the sample rate set by the frame divider.
// - Status bit 3 square wave, bits 2..0 sag C, B, A, upper bits zero.
// - Sag flag sets after sag count samples below threshold, clears above it.
`default_nettype none

package meim_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          SAMPLE_W        = 32;
  localparam int          NUM_HANDLES     = 11;
  localparam int          HANDLE_W        = 4;

  // Register addresses (engine word addresses)
  localparam logic [7:0]  RAW_LAST_ADDR   = 8'h0A;
  localparam logic [7:0]  ADDR_SEL_FIRST  = 8'h10;
  localparam logic [7:0]  ADDR_SEL_LAST   = 8'h1A;
  localparam logic [7:0]  ADDR_SAG_THRESHOLD    = 8'h24;
  localparam logic [7:0]  ADDR_STATUS     = 8'h80;
  localparam logic [7:0]  ADDR_IO_CFG     = 8'h90;
  localparam logic [7:0]  ADDR_PAIR_CFG   = 8'h91;
  localparam logic [7:0]  ADDR_SAG_SAMPLE_COUNT    = 8'h92;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h93;
  localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h94;
  localparam logic [7:0]  ADDR_IRQ_EN     = 8'h95;

  // Io config fields
  localparam int          EQU_LSB         = 5;
  localparam int          EQU_MSB         = 7;
  localparam int          DIV_LSB         = 0;
  localparam int          DIV_MSB         = 3;
  // Pair config fields
  localparam int          DIFF0_BIT       = 0;
  localparam int          DIFF2_BIT       = 1;
  localparam int          DIFF4_BIT       = 2;
  localparam int          DIFF6_BIT       = 3;
  localparam int          RMT2_BIT        = 4;
  localparam int          RMT4_BIT        = 5;
  localparam int          RMT6_BIT        = 6;
  // Status bits
  localparam int          ST_SQW_BIT      = 3;
  localparam int          ST_W            = 4;
  // Interrupt status bits
  localparam int          IRQ_PASS_BIT    = 0;
  localparam int          IRQ_SAG_BIT     = 1;
  localparam int          IRQ_W           = 2;

  localparam logic [2:0]  EQU_RESET       = 3'h5;
  localparam logic [3:0]  DIV_RESET       = 4'h7;
  localparam logic [11:0] SAG_SAMPLE_COUNT_RESET   = 12'h0DA;
  localparam logic [31:0] SAG_THRESHOLD_RESET   = 32'h0000_0000;
  localparam logic [3:0]  HANDLE_VA       = 4'h8;

  // Sample rate: 32768 Hz reference, 15 cycles per frame at divider 7
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          REF_HZ          = 32768;
  localparam int          REF_TICK_CYC    = CLK_HZ / REF_HZ;
  // Frame start tick settles; first slot then converts two ticks
  localparam int          FRAME_REF_BASE  = 2;
  localparam int          CONV_REF_CYC    = 2;
  localparam int          TICK_W          = 12;
  localparam int          FRM_W           = 5;

  typedef enum logic [1:0] {
    MEIM_IDLE   = 2'b00,
    MEIM_CONV   = 2'b01,
    MEIM_STORE  = 2'b10
  } meim_state_e;

endpackage : meim_pkg

`default_nettype wire

// ==== verilog/meim_slot_map.sv ====
// Handle to storage location decode for the input multiplexer
`default_nettype none

module meim_slot_map (
  input  wire logic [3:0] i_handle,        // Slot select value
  input  wire logic [6:0] i_pair_cfg,      // Differential and remote enables
  output logic            o_store,         // Handle produces a sample
  output logic [3:0]      o_loc            // Storage location
);

  logic odd_diff;
  logic pair_rmt;

  always_comb
  begin
    odd_diff = 1'b0;
    pair_rmt = 1'b0;
    unique case (i_handle)
      4'h0, 4'h1: odd_diff = i_pair_cfg[meim_pkg::DIFF0_BIT];
      4'h2, 4'h3:
      begin
        odd_diff = i_pair_cfg[meim_pkg::DIFF2_BIT];
        pair_rmt = i_pair_cfg[meim_pkg::RMT2_BIT];
      end
      4'h4, 4'h5:
      begin
        odd_diff = i_pair_cfg[meim_pkg::DIFF4_BIT];
        pair_rmt = i_pair_cfg[meim_pkg::RMT4_BIT];
      end
      4'h6, 4'h7:
      begin
        odd_diff = i_pair_cfg[meim_pkg::DIFF6_BIT];
        pair_rmt = i_pair_cfg[meim_pkg::RMT6_BIT];
      end
      default: ;
    endcase
    // Remote pairs are fed by the link; odd handles of diff pairs unused
    o_store = (i_handle <= meim_pkg::RAW_LAST_ADDR[3:0]) && !pair_rmt
              && !(odd_diff && i_handle[0] && i_handle < meim_pkg::HANDLE_VA);
    o_loc   = i_handle;
  end

endmodule : meim_slot_map

`default_nettype wire

// ==== verilog/meim_sag_det.sv ====
// Per-phase sag detector with sample-count qualification
`default_nettype none

module meim_sag_det (
  input  wire logic               i_sys_clk,   // System clock
  input  wire logic               i_rstn,      // Async reset, active low
  input  wire logic               i_smp_vld,   // New voltage sample
  input  wire logic signed [31:0] i_sample,    // Voltage sample
  input  wire logic signed [31:0] i_thr,       // Sag threshold
  input  wire logic [11:0]        i_cnt,       // Sag sample count
  output logic                    o_sag        // Sag flag
);

  typedef struct packed {
    logic [11:0] below;
    logic        sag;
  } meim_sag_s;

  meim_sag_s st_reg;
  meim_sag_s st_next;
  logic [31:0] mag;

  always_comb
  begin
    st_next = st_reg;
    mag     = i_sample[31] ? 32'(-i_sample) : i_sample;
    if (i_smp_vld)
    begin
      if ($signed(mag) < i_thr)
      begin
        if (st_reg.below < i_cnt)
          st_next.below = st_reg.below + 12'h001;
        if (st_reg.below + 12'h001 >= i_cnt)
          st_next.sag = 1'b1;
      end
      else if ($signed(mag) > i_thr)
      begin
        st_next.below = 12'h000;
        st_next.sag   = 1'b0;
      end
      else
        st_next.below = 12'h000;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_sag = st_reg.sag;

endmodule : meim_sag_det

`default_nettype wire

// ==== verilog/meim_top.sv ====
// Metering engine input map: sample slots, equation select, status and pass interrupt
`default_nettype none

module meim_top (
  input  wire logic        i_sys_clk,     // System clock 100 MHz
  input  wire logic        i_rstn,        // Async reset, active low
  input  wire logic [7:0]  i_addr,        // Register word address
  input  wire logic [31:0] i_wdata,       // Write data
  input  wire logic        i_wr,          // Write strobe
  input  wire logic        i_rd,          // Read strobe
  output logic      [31:0] o_rdata,       // Read data, cycle after strobe
  input  wire logic [31:0] i_adc_data,    // Converter result for current slot
  input  wire logic        i_rmt_vld,     // Isolation link sample strobe
  input  wire logic [1:0]  i_rmt_pair,    // Link pair: 1=pair2,2=pair4,3=pair6
  input  wire logic [31:0] i_rmt_data,    // Link sample
  output logic [3:0]       o_handle,      // Handle on multiplexer
  output logic             o_irq,         // Interrupt, level high
  output logic             o_pass,        // One-cycle pass pulse
  output logic [2:0]       o_equation_select // Equation in force
);

  localparam int SW = meim_pkg::SAMPLE_W;

  // ==========================================================
  // State
  typedef struct packed {
    meim_pkg::meim_state_e                state;
    logic [meim_pkg::TICK_W-1:0]          tick;
    logic [meim_pkg::FRM_W-1:0]           ref_cnt;
    logic [3:0]                           slot;
    logic [3:0]                           handle;
    logic [10:0][3:0]                     slot_sel;
    logic [10:0][SW-1:0]                  raw;
    logic [7:0]                           io_cfg;
    logic [6:0]                           pair_cfg;
    logic [31:0]                          sag_threshold;
    logic [11:0]                          sag_sample_count;
    logic [meim_pkg::IRQ_W-1:0]           irq_stat;
    logic [meim_pkg::IRQ_W-1:0]           irq_en;
    logic [meim_pkg::ST_W-1:0]            status;
    logic                                 va_pos;
    logic [31:0]                          rdata;
    logic                                 irq;
    logic                                 pass;
  } meim_top_s;

  meim_top_s st_reg;
  meim_top_s st_next;

  logic       map_store;
  logic [3:0] map_loc;
  logic [2:0] sag;
  logic [2:0] sag_vld;
  logic [3:0] div;
  logic [3:0] rmt_loc;
  logic       rmt_ok;

  assign div = st_reg.io_cfg[meim_pkg::DIV_MSB:meim_pkg::DIV_LSB];

  meim_slot_map u_map (
    .i_handle   (st_reg.handle),
    .i_pair_cfg (st_reg.pair_cfg),
    .o_store    (map_store),
    .o_loc      (map_loc)
  );

  // ==========================================================
  // Sag detectors for voltages on locations 8, 9, 10
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sag
      assign sag_vld[g] = (st_reg.state == meim_pkg::MEIM_STORE) && map_store
                          && (map_loc == meim_pkg::HANDLE_VA + 4'(g));
      meim_sag_det u_sag (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_smp_vld (sag_vld[g]),
        .i_sample  (i_adc_data),
        .i_thr     (st_reg.sag_threshold),
        .i_cnt     (st_reg.sag_sample_count),
        .o_sag     (sag[g])
      );
    end
  endgenerate

  // Remote pair index to even location; voltages never remote
  always_comb
  begin
    rmt_loc = {1'b0, i_rmt_pair, 1'b0};
    unique case (i_rmt_pair)
      2'h1:    rmt_ok = st_reg.pair_cfg[meim_pkg::RMT2_BIT];
      2'h2:    rmt_ok = st_reg.pair_cfg[meim_pkg::RMT4_BIT];
      2'h3:    rmt_ok = st_reg.pair_cfg[meim_pkg::RMT6_BIT];
      default: rmt_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next      = st_reg;
    st_next.pass = 1'b0;

    // Reference tick divider (32768 Hz)
    if (st_reg.tick == meim_pkg::TICK_W'(meim_pkg::REF_TICK_CYC - 1))
      st_next.tick = '0;
    else
      st_next.tick = st_reg.tick + 1'b1;

    // Frame: one settling tick then two ticks per conversion per slot
    unique case (st_reg.state)
      meim_pkg::MEIM_IDLE:
      begin
        st_next.handle = st_reg.slot_sel[0];
        if (st_reg.tick == '0)
        begin
          st_next.state   = meim_pkg::MEIM_CONV;
          st_next.slot    = 4'h0;
          st_next.ref_cnt = meim_pkg::FRM_W'(meim_pkg::FRAME_REF_BASE);
        end
      end
      meim_pkg::MEIM_CONV:
      begin
        if (st_reg.tick == '0)
        begin
          if (st_reg.ref_cnt == 1)
            st_next.state = meim_pkg::MEIM_STORE;
          else
            st_next.ref_cnt = st_reg.ref_cnt - 1'b1;
        end
      end
      meim_pkg::MEIM_STORE:
      begin
        if (map_store)
          st_next.raw[map_loc] = i_adc_data;
        st_next.ref_cnt = meim_pkg::FRM_W'(meim_pkg::CONV_REF_CYC);
        if (st_reg.slot + 4'h1 >= div)
        begin
          // Pass ends once per frame: sample-rate interrupt
          st_next.state = meim_pkg::MEIM_IDLE;
          st_next.pass  = 1'b1;
          st_next.irq_stat[meim_pkg::IRQ_PASS_BIT] = 1'b1;
        end
        else
        begin
          st_next.state  = meim_pkg::MEIM_CONV;
          st_next.slot   = st_reg.slot + 4'h1;
          st_next.handle = st_reg.slot_sel[st_reg.slot + 4'h1];
        end
      end
      default: st_next.state = meim_pkg::MEIM_IDLE;
    endcase

    // Remote link writes straight into even locations, held until next write
    if (i_rmt_vld && rmt_ok)
      st_next.raw[rmt_loc] = i_rmt_data;

    // Status word: sag C,B,A and fundamental square wave from VA sign
    if (sag_vld[0])
      st_next.va_pos = ~i_adc_data[31];
    st_next.status = {st_reg.va_pos, sag};
    if ((sag & ~st_reg.status[2:0]) != 3'h0)
      st_next.irq_stat[meim_pkg::IRQ_SAG_BIT] = 1'b1;

    // Register writes and reads
    st_next.rdata = 32'h0000_0000;
    if (i_wr)
    begin
      unique case (i_addr)
        meim_pkg::ADDR_IO_CFG:   st_next.io_cfg   = i_wdata[7:0];
        meim_pkg::ADDR_PAIR_CFG: st_next.pair_cfg = i_wdata[6:0];
        meim_pkg::ADDR_SAG_THRESHOLD:  st_next.sag_threshold  = i_wdata;
        meim_pkg::ADDR_SAG_SAMPLE_COUNT:  st_next.sag_sample_count  = i_wdata[11:0];
        meim_pkg::ADDR_IRQ_EN:   st_next.irq_en   = i_wdata[meim_pkg::IRQ_W-1:0];
        // Set wins only for bits rising 0 to 1 this cycle; clear drops bits already set, even if set again
        meim_pkg::ADDR_IRQ_CLR:
          st_next.irq_stat = st_next.irq_stat
                             & ~(i_wdata[meim_pkg::IRQ_W-1:0] & ~(st_next.irq_stat & ~st_reg.irq_stat));
        default:
        begin
          if (i_addr >= meim_pkg::ADDR_SEL_FIRST && i_addr <= meim_pkg::ADDR_SEL_LAST)
            st_next.slot_sel[i_addr[3:0]] = i_wdata[3:0];
        end
      endcase
    end
    if (i_rd)
    begin
      if (i_addr <= meim_pkg::RAW_LAST_ADDR)
        st_next.rdata = st_reg.raw[i_addr[3:0]];
      else if (i_addr >= meim_pkg::ADDR_SEL_FIRST && i_addr <= meim_pkg::ADDR_SEL_LAST)
        st_next.rdata = {28'h0, st_reg.slot_sel[i_addr[3:0]]};
      else
        unique case (i_addr)
          meim_pkg::ADDR_STATUS:   st_next.rdata = {28'h0, st_reg.status};
          meim_pkg::ADDR_IO_CFG:   st_next.rdata = {24'h0, st_reg.io_cfg};
          meim_pkg::ADDR_PAIR_CFG: st_next.rdata = {25'h0, st_reg.pair_cfg};
          meim_pkg::ADDR_SAG_THRESHOLD:  st_next.rdata = st_reg.sag_threshold;
          meim_pkg::ADDR_SAG_SAMPLE_COUNT:  st_next.rdata = {20'h0, st_reg.sag_sample_count};
          meim_pkg::ADDR_IRQ_STAT: st_next.rdata = {30'h0, st_reg.irq_stat};
          meim_pkg::ADDR_IRQ_EN:   st_next.rdata = {30'h0, st_reg.irq_en};
          default:                 st_next.rdata = 32'h0000_0000;
        endcase
    end
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg          <= '0;
      st_reg.io_cfg   <= {meim_pkg::EQU_RESET, 1'b0, meim_pkg::DIV_RESET};
      st_reg.sag_sample_count  <= meim_pkg::SAG_SAMPLE_COUNT_RESET;
      st_reg.sag_threshold  <= meim_pkg::SAG_THRESHOLD_RESET;
      for (int i = 0; i < meim_pkg::NUM_HANDLES; i++)
        st_reg.slot_sel[i] <= 4'(i);
    end
    else
      st_reg <= st_next;
  end

  assign o_rdata           = st_reg.rdata;
  assign o_handle          = st_reg.handle;
  assign o_irq             = st_reg.irq;
  assign o_pass            = st_reg.pass;
  // Formula choice passed to the engine core; codes 2..5 meaningful
  assign o_equation_select = st_reg.io_cfg[meim_pkg::EQU_MSB:meim_pkg::EQU_LSB];

endmodule : meim_top

`default_nettype wire

// ==== sim/meim_afe_model.sv ====
// Converter model: answers each multiplexer handle with a tagged sample
`default_nettype none

module meim_afe_model (
  input  wire logic [3:0]  i_handle,   // Handle on multiplexer
  input  wire logic [7:0]  i_salt,     // Per-frame marker from bench
  output logic      [31:0] o_adc_data  // Converter result
);
  timeunit 1ns;
  timeprecision 1ps;
  // Handle in low nibble so a misplaced store shows which input it came from
  assign o_adc_data = {i_salt, 20'h0_0000, i_handle};
endmodule // meim_afe_model

`default_nettype wire

// ==== sim/meim_top_sva.sv ====
// Port-level checker for the metering engine input map
`default_nettype none

module meim_top_sva (
  input wire logic        i_sys_clk,         // System clock
  input wire logic        i_rstn,            // Async reset, active low
  input wire logic [7:0]  i_addr,            // Word address
  input wire logic [31:0] i_wdata,           // Write data
  input wire logic        i_wr,              // Write strobe
  input wire logic        i_rd,              // Read strobe
  input wire logic [31:0] o_rdata,           // Read data
  input wire logic [31:0] i_adc_data,        // Converter result
  input wire logic        i_rmt_vld,         // Link strobe
  input wire logic [1:0]  i_rmt_pair,        // Link pair
  input wire logic [31:0] i_rmt_data,        // Link sample
  input wire logic [3:0]  o_handle,          // Handle
  input wire logic        o_irq,             // Interrupt
  input wire logic        o_pass,            // Pass pulse
  input wire logic [2:0]  o_equation_select  // Equation
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shortest frame is three reference ticks
  localparam int GAP_MIN = 9000;
  logic [1:0]  en_q;
  logic [6:0]  pcfg_q;
  logic [31:0] rmt2_q;
  logic        seen_q;
  int          gap;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================
  // Shadow state from bus traffic
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      en_q   <= 2'h0;
      pcfg_q <= 7'h00;
      rmt2_q <= 32'h0;
      seen_q <= 1'b0;
      // No pass before the first one: start saturated
      gap    <= 100000;
    end
    else
    begin
      if (i_wr && i_addr == 8'h95) en_q <= i_wdata[1:0];
      if (i_wr && i_addr == 8'h91) pcfg_q <= i_wdata[6:0];
      if (i_wr && i_addr == 8'h91 && !i_wdata[4]) seen_q <= 1'b0;
      else if (i_rmt_vld && i_rmt_pair == 2'd1 && pcfg_q[4])
      begin
        rmt2_q <= i_rmt_data;
        seen_q <= 1'b1;
      end
      if (o_pass) gap <= 0;
      else if (gap < 100000) gap <= gap + 1;
    end
  end
  // ==========================================
  // Properties
  property p_status_zero; i_rd && i_addr == 8'h80 |=> o_rdata[31:4] == 28'h0; endproperty
  a_status_zero: assert property (p_status_zero) else $error("status upper bits set");
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_unmapped; i_rd && i_addr inside {[8'h40:8'h7F]} |=> o_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_off; en_q == 2'h0 && $past(en_q) == 2'h0 |-> !o_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
  property p_irq_pass; o_pass && en_q[0] && $past(en_q[0]) |-> ##[0:2] o_irq; endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("pass did not raise interrupt");
  property p_pass_pulse; o_pass |=> !o_pass; endproperty
  a_pass_pulse: assert property (p_pass_pulse) else $error("pass longer than one cycle");
  property p_pass_gap; o_pass |-> gap >= GAP_MIN; endproperty
  a_pass_gap: assert property (p_pass_gap) else $error("passes too close");
  property p_equ; i_wr && i_addr == 8'h90 |=> o_equation_select == $past(i_wdata[7:5]); endproperty
  a_equ: assert property (p_equ) else $error("equation select not taken");
  property p_handle; o_handle <= 4'hA; endproperty
  a_handle: assert property (p_handle) else $error("handle out of range");
  property p_remote; i_rd && i_addr == 8'h02 && pcfg_q[4] && seen_q |=> o_rdata == $past(rmt2_q); endproperty
  a_remote: assert property (p_remote) else $error("remote slot lost link sample");
endmodule // meim_top_sva

bind meim_top meim_top_sva meim_top_sva_i (.i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_adc_data, .i_rmt_vld, .i_rmt_pair, .i_rmt_data, .o_handle, .o_irq, .o_pass, .o_equation_select);

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the metering engine input map
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0;
  logic        i_rstn    = 1'b0;
  logic [7:0]  i_addr    = 8'h00;
  logic [31:0] i_wdata   = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        i_rmt_vld = 1'b0;
  logic [1:0]  i_rmt_pair = 2'd0;
  logic [31:0] i_rmt_data = 32'h0;
  logic [7:0]  salt      = 8'hA0;
  logic [31:0] o_rdata, adc, r, r4;
  logic [3:0]  o_handle;
  logic        o_irq, o_pass;
  logic [2:0]  o_equation_select;
  int          bad_count = 0;
  int          compares  = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  meim_afe_model meim_afe_model_i (.i_handle(o_handle), .i_salt(salt), .o_adc_data(adc));
  meim_top meim_top_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_adc_data(adc), .i_rmt_vld(i_rmt_vld),
    .i_rmt_pair(i_rmt_pair), .i_rmt_data(i_rmt_data), .o_handle(o_handle), .o_irq(o_irq),
    .o_pass(o_pass), .o_equation_select(o_equation_select));

  // ==========================================
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, r);
    chk(r & m, e);
  endtask
  task automatic send(input logic [1:0] p, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_rmt_vld <= 1'b1; i_rmt_pair <= p; i_rmt_data <= d;
    @(posedge i_sys_clk);
    i_rmt_vld <= 1'b0;
  endtask
  // Call in the idle gap after a pass, so the next frame runs wholly on the new setup
  task automatic frame(input logic [7:0] s, input logic [3:0] dv, input logic [15:0] hs);
    int n;
    salt <= s;
    for (n = 0; n < dv; n++) wr(8'h10 + n[7:0], {28'h0, hs[4*n +: 4]});
    wr(8'h90, {24'h0, 3'h5, 1'b0, dv});
    n = 0;
    while (n < 60000 && o_pass !== 1'b1)
    begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    chk({31'h0, o_pass}, 32'h1);
  endtask
  function automatic logic [31:0] smp(input logic [7:0] s, input logic [3:0] h);
    return {s, 20'h0_0000, h};
  endfunction
  task automatic end_sim;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #900000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    int k;
    logic [1:0] tp [3] = '{2'd1, 2'd3, 2'd2};
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    // ==========================================
    // Reset values and plain register access
    chk({29'h0, o_equation_select}, 32'h5);
    rd_chk(8'h90, 32'hFF, 32'hA7);
    rd_chk(8'h13, 32'hF, 32'h3);
    rd_chk(8'h92, 32'hFFF, 32'hDA);
    rd_chk(8'h50, 32'hFFFF_FFFF, 32'h0);
    wr(8'h80, 32'hFFFF_FFFF);
    rd_chk(8'h80, 32'hFFFF_FFF7, 32'h0);
    for (k = 2; k <= 5; k++)
    begin
      wr(8'h90, {24'h0, k[2:0], 5'h01});
      chk({29'h0, o_equation_select}, k);
    end
    $display("test registers done");
    // Short first frame; line up with the idle gap after its pass
    @(posedge o_pass);
    // ==========================================
    // Single-ended frame, then interrupt enable and clear
    frame(8'hA0, 4'h3, 16'h0931);
    rd_chk(8'h01, 32'hFFFF_FFFF, smp(8'hA0, 4'h1));
    rd_chk(8'h03, 32'hFFFF_FFFF, smp(8'hA0, 4'h3));
    rd_chk(8'h09, 32'hFFFF_FFFF, smp(8'hA0, 4'h9));
    rd_chk(8'h80, 32'hFFFF_FFF7, 32'h0);
    rd_chk(8'h93, 32'h1, 32'h1);
    wr(8'h95, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk({31'h0, o_irq}, 32'h1);
    wr(8'h94, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk({31'h0, o_irq}, 32'h0);
    $display("test frame one done");
    // ==========================================
    // Remote link: pairs 2 and 6 remote, pair 4 local refuses
    rd(8'h04, r4);
    wr(8'h91, 32'h53);
    for (k = 0; k < 3; k++)
    begin
      send(tp[k], 32'h1234_5000 | k);
      rd_chk({5'h0, tp[k], 1'b0}, 32'hFFFF_FFFF, (k == 2) ? r4 : (32'h1234_5000 | k));
    end
    send(2'd0, 32'h5555_AAAA);
    rd_chk(8'h00, 32'hFFFF_FFFF, smp(8'hA0, 4'h0));
    $display("test remote done");
    // ==========================================
    // Differential and remote mapping, sag set
    wr(8'h24, 32'h7FFF_FFFF);
    wr(8'h92, 32'h1);
    frame(8'hB0, 4'h4, 16'h8210);
    rd_chk(8'h00, 32'hFFFF_FFFF, smp(8'hB0, 4'h0));
    rd_chk(8'h01, 32'hFFFF_FFFF, smp(8'hA0, 4'h1));
    rd_chk(8'h02, 32'hFFFF_FFFF, 32'h1234_5000);
    rd_chk(8'h08, 32'hFFFF_FFFF, smp(8'hB0, 4'h8));
    rd_chk(8'h80, 32'hFFFF_FFF7, 32'h1);
    rd_chk(8'h93, 32'h3, 32'h3);
    chk({31'h0, o_irq}, 32'h1);
    wr(8'h94, 32'h3);
    $display("test frame two done");
    // ==========================================
    // Local differential pair 2, sag clears
    wr(8'h91, 32'h02);
    wr(8'h24, 32'h0);
    frame(8'hC0, 4'h2, 16'h0083);
    rd_chk(8'h03, 32'hFFFF_FFFF, smp(8'hA0, 4'h3));
    rd_chk(8'h08, 32'hFFFF_FFFF, smp(8'hC0, 4'h8));
    rd_chk(8'h80, 32'hFFFF_FFF7, 32'h0);
    chk({28'h0, o_handle}, 32'h3);
    $display("test frame three done");
    end_sim();
  end
endmodule // tb_top

`default_nettype wire
